// *** rtl/hpr_pkg.sv ***
// constants and carrier types for the headphone channel control registers
// assumes a single 100 MHz clock and an AXI4-Lite master with 32-bit data
// Functional notes
// R01: decay code maps linearly, 10 dB/s per step
// R02: band code 0..6 selects 120..12000 Hz
// R03: gain code in 0.5 dB steps, 0x18 flat
// R04: equalizer register resets to 0x0018
// R05: host writes reserved bits as zero
// R06: coefficients are signed 28-bit 5.23 words
// R07: left balance = high[11:0] over low[15:0]
// R08: right balance assembled like left balance
// R09: volume = high[11:0] over low[15:0]
// R10: volume pair resets to 0x0080, 0x0000
// R11: balance pairs reset to 0x0080, 0x0000
// R12: coefficient applied whole after both halves written
package hpr_pkg;

	// register indices; byte address is four times the index
	localparam logic [29:0] IDX_EQ          = 30'h0000_0118;
	localparam logic [29:0] IDX_LEFT_HIGH   = 30'h0000_011A;
	localparam logic [29:0] IDX_LEFT_LOW    = 30'h0000_011B;
	localparam logic [29:0] IDX_RIGHT_HIGH  = 30'h0000_011C;
	localparam logic [29:0] IDX_RIGHT_LOW   = 30'h0000_011D;
	localparam logic [29:0] IDX_VOLUME_HIGH = 30'h0000_011E;
	localparam logic [29:0] IDX_VOLUME_LOW  = 30'h0000_011F;
	localparam logic [29:0] IDX_DECAY       = 30'h0000_0130;

	// coefficient pairs: 0 left balance, 1 right balance, 2 volume
	localparam int          NUM_PAIRS       = 3;
	localparam logic [29:0] IDX_PAIR_BASE   = IDX_LEFT_HIGH;

	// values after reset
	localparam logic [15:0] RST_EQ          = 16'h0018;
	localparam logic [11:0] RST_COEF_HIGH   = 12'h080;
	localparam logic [15:0] RST_COEF_LOW    = 16'h0000;
	localparam logic [4:0]  RST_DECAY       = 5'h00;

	// writable bits; everything else is reserved and reads zero
	localparam logic [15:0] EQ_MASK         = 16'h073F;
	localparam logic [15:0] HIGH_MASK       = 16'h0FFF;
	localparam logic [15:0] DECAY_MASK      = 16'h001F;

	// field positions and code maps
	localparam int          EQ_BAND_LSB     = 8;
	localparam int          EQ_GAIN_LSB     = 0;
	localparam logic [2:0]  EQ_BAND_LAST    = 3'h6;
	localparam logic [5:0]  EQ_GAIN_MAX     = 6'h30;
	localparam logic [6:0]  EQ_GAIN_FLAT    = 7'h18;
	localparam logic [8:0]  DECAY_STEP_DBS  = 9'h00A;
	localparam logic [6:0][13:0] EQ_BAND_HZ = {14'h2EE0, 14'h1D4C, 14'h0BB8,
		14'h04B0, 14'h01F4, 14'h00C8, 14'h0078};

	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;

	// settings handed to the audio path
	typedef struct packed {
		logic [2:0]         eq_band;
		logic               eq_band_valid;
		logic [13:0]        eq_freq_hz;
		logic signed [6:0]  eq_gain_half_db;
		logic signed [27:0] left_balance;
		logic signed [27:0] right_balance;
		logic signed [27:0] volume;
		logic [4:0]         decay_code;
		logic [8:0]         decay_rate_dbs;
	} hpr_ctrl_t;

	typedef struct packed {
		logic                        have_aw;
		logic                        have_w;
		logic [29:0]                 awidx;
		logic [15:0]                 wdata;
		logic [1:0]                  wstrb;
		logic                        bvalid;
		logic [1:0]                  bresp;
		logic                        rvalid;
		logic [15:0]                 rdata;
		logic [1:0]                  rresp;
		logic [15:0]                 eq;
		logic [4:0]                  decay;
		logic [NUM_PAIRS-1:0][11:0]  high;
		logic [NUM_PAIRS-1:0][15:0]  low;
		logic [NUM_PAIRS-1:0][1:0]   pend;
		logic [NUM_PAIRS-1:0][27:0]  act;
		hpr_ctrl_t                   ctrl;
	} hpr_state_t;

endpackage

// *** rtl/hpr_regs.sv ***
// headphone channel equalizer, balance, volume and limiter decay registers
// assumes an AXI4-Lite master on aclk; settings go to the audio path as one struct
`timescale 1ns/1ns
module hpr_regs
(
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// write address and data
	input  wire logic [31:0]       awaddr,
	input  wire logic [2:0]        awprot,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	// write response
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	// read address and data
	input  wire logic [31:0]       araddr,
	input  wire logic [2:0]        arprot,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// settings for the audio path
	output hpr_pkg::hpr_ctrl_t     ctrl
);

	hpr_pkg::hpr_state_t st;
	hpr_pkg::hpr_state_t next_st;
	logic                wr_fire;

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] val,
		input logic [1:0] strb, input logic [15:0] mask);
		logic [15:0] m;
		m = old;
		if (strb[0])
			m[7:0] = val[7:0];
		if (strb[1])
			m[15:8] = val[15:8];
		return m & mask;
	endfunction

	assign awready = !st.have_aw && !st.bvalid;
	assign wready  = !st.have_w && !st.bvalid;
	assign arready = !st.rvalid;
	assign bvalid  = st.bvalid;
	assign bresp   = st.bresp;
	assign rvalid  = st.rvalid;
	assign rresp   = st.rresp;
	assign rdata   = {16'h0000, st.rdata};
	assign ctrl    = st.ctrl;
	assign wr_fire = st.have_aw && st.have_w;

	always_comb
	begin
		logic        hit;
		logic [15:0] rd;
		logic [15:0] tmp;
		logic [5:0]  gain;
		hit = 1'b0;
		rd = 16'h0000;
		tmp = 16'h0000;
		gain = 6'h00;
		next_st = st;
		if (st.bvalid && bready)
			next_st.bvalid = 1'b0;
		if (st.rvalid && rready)
			next_st.rvalid = 1'b0;
		if (awvalid && awready)
		begin
			next_st.have_aw = 1'b1;
			next_st.awidx = awaddr[31:2];
		end
		if (wvalid && wready)
		begin
			next_st.have_w = 1'b1;
			next_st.wdata = wdata[15:0];
			next_st.wstrb = wstrb[1:0];
		end
		// write takes effect once address and data are both held
		if (wr_fire)
		begin
			next_st.have_aw = 1'b0;
			next_st.have_w = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = hpr_pkg::RESP_OKAY;
			// reserved bits are dropped, so a careless host cannot set them
			if (st.awidx == hpr_pkg::IDX_EQ)
			begin
				next_st.eq = merge(st.eq, st.wdata, st.wstrb, hpr_pkg::EQ_MASK); // R05
				hit = 1'b1;
			end
			if (st.awidx == hpr_pkg::IDX_DECAY)
			begin
				tmp = merge({11'h000, st.decay}, st.wdata, st.wstrb, hpr_pkg::DECAY_MASK);
				next_st.decay = tmp[4:0];
				hit = 1'b1;
			end
			for (int p = 0; p < hpr_pkg::NUM_PAIRS; p++)
			begin
				if (st.awidx == hpr_pkg::IDX_PAIR_BASE + 30'(2 * p))
				begin
					tmp = merge({4'h0, st.high[p]}, st.wdata, st.wstrb, hpr_pkg::HIGH_MASK);
					next_st.high[p] = tmp[11:0];
					next_st.pend[p][1] = 1'b1;
					hit = 1'b1;
				end
				if (st.awidx == hpr_pkg::IDX_PAIR_BASE + 30'(2 * p + 1))
				begin
					next_st.low[p] = merge(st.low[p], st.wdata, st.wstrb, 16'hFFFF);
					next_st.pend[p][0] = 1'b1;
					hit = 1'b1;
				end
			end
			if (!hit)
				next_st.bresp = hpr_pkg::RESP_SLVERR;
		end
		// whole-word commit; a half alone never reaches the audio path
		for (int p = 0; p < hpr_pkg::NUM_PAIRS; p++)
		begin
			if (next_st.pend[p] == 2'h3)
			begin
				next_st.act[p] = {next_st.high[p], next_st.low[p]}; // R07 R08 R09 R12
				next_st.pend[p] = 2'h0;
			end
		end
		if (arvalid && arready)
		begin
			hit = 1'b0;
			if (araddr[31:2] == hpr_pkg::IDX_EQ)
			begin
				rd = st.eq;
				hit = 1'b1;
			end
			if (araddr[31:2] == hpr_pkg::IDX_DECAY)
			begin
				rd = {11'h000, st.decay};
				hit = 1'b1;
			end
			for (int p = 0; p < hpr_pkg::NUM_PAIRS; p++)
			begin
				if (araddr[31:2] == hpr_pkg::IDX_PAIR_BASE + 30'(2 * p))
				begin
					rd = {4'h0, st.high[p]};
					hit = 1'b1;
				end
				if (araddr[31:2] == hpr_pkg::IDX_PAIR_BASE + 30'(2 * p + 1))
				begin
					rd = st.low[p];
					hit = 1'b1;
				end
			end
			next_st.rvalid = 1'b1;
			next_st.rdata = rd;
			next_st.rresp = hit ? hpr_pkg::RESP_OKAY : hpr_pkg::RESP_SLVERR;
		end
		if (!aresetn)
		begin
			next_st = '0;
			next_st.eq = hpr_pkg::RST_EQ; // R04
			next_st.decay = hpr_pkg::RST_DECAY;
			for (int p = 0; p < hpr_pkg::NUM_PAIRS; p++)
			begin
				next_st.high[p] = hpr_pkg::RST_COEF_HIGH; // R10 R11
				next_st.low[p] = hpr_pkg::RST_COEF_LOW;
				next_st.act[p] = {hpr_pkg::RST_COEF_HIGH, hpr_pkg::RST_COEF_LOW};
			end
		end
		// decoded settings, registered with the state they come from
		next_st.ctrl.eq_band = next_st.eq[hpr_pkg::EQ_BAND_LSB +: 3];
		next_st.ctrl.eq_band_valid = next_st.ctrl.eq_band <= hpr_pkg::EQ_BAND_LAST;
		next_st.ctrl.eq_freq_hz = next_st.ctrl.eq_band_valid ?
			hpr_pkg::EQ_BAND_HZ[next_st.ctrl.eq_band] : 14'h0000; // R02
		// codes past the last step clamp to the deepest cut
		gain = next_st.eq[hpr_pkg::EQ_GAIN_LSB +: 6];
		if (gain > hpr_pkg::EQ_GAIN_MAX)
			gain = hpr_pkg::EQ_GAIN_MAX;
		next_st.ctrl.eq_gain_half_db = hpr_pkg::EQ_GAIN_FLAT - {1'b0, gain}; // R03
		next_st.ctrl.left_balance = next_st.act[0]; // R06
		next_st.ctrl.right_balance = next_st.act[1];
		next_st.ctrl.volume = next_st.act[2];
		next_st.ctrl.decay_code = next_st.decay;
		next_st.ctrl.decay_rate_dbs = (9'(next_st.decay) + 9'h001) * hpr_pkg::DECAY_STEP_DBS; // R01
	end

	always_ff @(posedge aclk)
	begin
		st <= next_st;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	eq_reset_val_a: assert property ($past(!aresetn) |-> st.eq == 16'h0018) // R04
		else $error("equalizer register wrong after reset");
	vol_reset_val_a: assert property ($past(!aresetn) |-> ctrl.volume == 28'h0800000) // R10
		else $error("volume not unity after reset");
	bal_reset_val_a: assert property ($past(!aresetn) |-> // R11
		ctrl.left_balance == 28'h0800000 && ctrl.right_balance == 28'h0800000)
		else $error("balance not unity after reset");
	gain_map_a: assert property (st.eq[5:0] <= 6'h30 |-> // R03
		ctrl.eq_gain_half_db == 7'sh18 - $signed({1'b0, st.eq[5:0]}))
		else $error("equalizer gain code mapped wrongly");
	gain_top_a: assert property (st.eq[5:0] == 6'h00 |-> // R03
		ctrl.eq_gain_half_db == 7'sh18)
		else $error("equalizer full boost wrong");
	gain_seven_a: assert property (st.eq[5:0] == 6'h0A |-> // R03
		ctrl.eq_gain_half_db == 7'sh0E)
		else $error("equalizer plus seven point wrong");
	gain_minus_a: assert property (st.eq[5:0] == 6'h26 |-> // R03
		ctrl.eq_gain_half_db == -7'sh0E)
		else $error("equalizer minus seven point wrong");
	// undefined codes must never boost; the deepest cut is the safe side
	gain_clamp_a: assert property (st.eq[5:0] > 6'h30 |-> // R03
		ctrl.eq_gain_half_db == -7'sh18)
		else $error("equalizer gain past last step not clamped");
	band_field_a: assert property (ctrl.eq_band == st.eq[10:8] && // R02
		ctrl.eq_band_valid == (st.eq[10:8] != 3'h7))
		else $error("equalizer band field decoded wrongly");
	band_zero_a: assert property (st.eq[10:8] == 3'h0 |-> ctrl.eq_freq_hz == 14'h0078) // R02
		else $error("band 0 frequency wrong");
	band_one_a: assert property (st.eq[10:8] == 3'h1 |-> ctrl.eq_freq_hz == 14'h00C8) // R02
		else $error("band 1 frequency wrong");
	band_two_a: assert property (st.eq[10:8] == 3'h2 |-> ctrl.eq_freq_hz == 14'h01F4) // R02
		else $error("band 2 frequency wrong");
	band_three_a: assert property (st.eq[10:8] == 3'h3 |-> ctrl.eq_freq_hz == 14'h04B0) // R02
		else $error("band 3 frequency wrong");
	band_four_a: assert property (st.eq[10:8] == 3'h4 |-> ctrl.eq_freq_hz == 14'h0BB8) // R02
		else $error("band 4 frequency wrong");
	band_five_a: assert property (st.eq[10:8] == 3'h5 |-> ctrl.eq_freq_hz == 14'h1D4C) // R02
		else $error("band 5 frequency wrong");
	band_freq_a: assert property (st.eq[10:8] == 3'h6 |-> ctrl.eq_freq_hz == 14'h2EE0) // R02
		else $error("top band frequency wrong");
	band_none_a: assert property (st.eq[10:8] == 3'h7 |-> ctrl.eq_freq_hz == 14'h0000) // R02
		else $error("undefined band not silenced");
	decay_code_a: assert property (ctrl.decay_code == st.decay) // R01
		else $error("decay code not passed on");
	decay_base_a: assert property (st.decay == 5'h00 |-> ctrl.decay_rate_dbs == 9'h00A) // R01
		else $error("lowest decay rate wrong");
	decay_mid_a: assert property (st.decay == 5'h13 |-> ctrl.decay_rate_dbs == 9'h0C8) // R01
		else $error("middle decay rate wrong");
	decay_top_a: assert property (st.decay == 5'h1F |-> ctrl.decay_rate_dbs == 9'h140) // R01
		else $error("top decay rate wrong");
	eq_reserved_a: assert property ((st.eq & 16'hF8C0) == 16'h0000) // R05
		else $error("reserved equalizer bits set");
	pair_reset_a: assert property ($past(!aresetn) |-> // R10 R11
		st.high == {3{12'h080}} && st.low == 48'h0000_0000_0000)
		else $error("coefficient halves wrong after reset");
	vol_whole_a: assert property ($changed(ctrl.volume) |-> // R12
		$past(wr_fire) && st.pend[2] == 2'h0 && $past(st.pend[2]) != 2'h0)
		else $error("volume changed without completing a pair");
	left_join_a: assert property ($past(wr_fire) && $past(st.pend[0]) != 2'h0 && // R07
		st.pend[0] == 2'h0 |-> ctrl.left_balance == {st.high[0], st.low[0]})
		else $error("left balance assembled wrongly");
	right_join_a: assert property ($past(wr_fire) && $past(st.pend[1]) != 2'h0 && // R08
		st.pend[1] == 2'h0 |-> ctrl.right_balance == {st.high[1], st.low[1]})
		else $error("right balance assembled wrongly");
	vol_sign_a: assert property ($changed(ctrl.volume) |-> // R06 R09
		ctrl.volume[27:16] == st.high[2] && ctrl.volume[15:0] == st.low[2])
		else $error("volume word sign or upper bits wrong");
	left_whole_a: assert property ($changed(ctrl.left_balance) |-> // R12
		$past(wr_fire) && st.pend[0] == 2'h0 && $past(st.pend[0]) != 2'h0)
		else $error("left balance changed without completing a pair");
	right_whole_a: assert property ($changed(ctrl.right_balance) |-> // R12
		$past(wr_fire) && st.pend[1] == 2'h0 && $past(st.pend[1]) != 2'h0)
		else $error("right balance changed without completing a pair");
	// a half write must leave the audio path alone, or it would play a torn word
	left_hold_a: assert property (st.pend[0] != 2'h0 |-> $stable(ctrl.left_balance)) // R12
		else $error("left balance moved on a half write");
	right_hold_a: assert property (st.pend[1] != 2'h0 |-> $stable(ctrl.right_balance)) // R12
		else $error("right balance moved on a half write");
	vol_hold_a: assert property (st.pend[2] != 2'h0 |-> $stable(ctrl.volume)) // R12
		else $error("volume moved on a half write");
	// answers must stand until taken, or a slow master loses them
	resp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped before it was taken");
	read_hold_a: assert property (rvalid && !rready |=>
		rvalid && $stable(rdata) && $stable(rresp))
		else $error("read response dropped before it was taken");
	write_ans_a: assert property ($past(wr_fire) |-> bvalid)
		else $error("write response missing");
	busy_ready_a: assert property (bvalid |-> !awready && !wready)
		else $error("write channel accepted while response pending");
	rdata_upper_a: assert property (rdata[31:16] == 16'h0000)
		else $error("upper read data lanes not zero");

	eq_write_c: cover property (wr_fire && st.awidx == hpr_pkg::IDX_EQ);
	vol_commit_c: cover property ($changed(ctrl.volume));
	bad_read_c: cover property (rvalid && rresp == hpr_pkg::RESP_SLVERR);
	same_cycle_c: cover property (awvalid && wvalid && awready && wready);
	band_off_c: cover property (ctrl.eq_band_valid == 1'b0);

endmodule

// *** tb/tb.sv ***
// self-checking bench for the headphone channel control registers
// assumes hpr_pkg and hpr_regs are compiled first; the bench is the AXI4-Lite master
`timescale 1ns/1ns
module tb;
	logic               aclk    = 1'b0;
	logic               aresetn = 1'b0;
	logic [31:0]        awaddr  = 32'h0000_0000;
	logic               awvalid = 1'b0;
	logic               awready;
	logic [31:0]        wdata   = 32'h0000_0000;
	logic               wvalid  = 1'b0;
	logic               wready;
	logic [1:0]         bresp;
	logic               bvalid;
	logic               bready  = 1'b0;
	logic [31:0]        araddr  = 32'h0000_0000;
	logic               arvalid = 1'b0;
	logic               arready;
	logic [31:0]        rdata;
	logic [1:0]         rresp;
	logic               rvalid;
	logic               rready  = 1'b0;
	hpr_pkg::hpr_ctrl_t ctrl;
	int                 err_count = 0;
	int                 compares  = 0;
	int                 i;
	logic [1:0]         r;
	logic [31:0]        d;
	logic [11:0]        hi;
	logic [15:0]        lo;
	logic [29:0]        ix;
	// 120, 200, 500, 1200, 3000, 7500, 12000 Hz
	localparam logic [31:0] HZ [7] = '{32'h78, 32'hC8, 32'h1F4, 32'h4B0, 32'hBB8, 32'h1D4C, 32'h2EE0};
	localparam int          GC [7] = '{8'h00, 8'h18, 8'h30, 8'h01, 8'h2F, 8'h0A, 8'h26};
	localparam int          DC [3] = '{8'h00, 8'h13, 8'h1F};

	always #5 aclk = ~aclk;

	hpr_regs i_hpr_regs (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .ctrl(ctrl));

	task automatic close_out;
		$display("counts: compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		chk({30'h0, got}, {30'h0, exp}, "response");
	endtask

	task automatic fail_wait;
		err_count++;
		$display("unexpected at %0t: bus answer never came", $time);
		close_out();
	endtask

	// holds each channel until its own ready; samples at the negedge before the taking edge
	task automatic wr(input logic [29:0] idx, input logic [15:0] v, output logic [1:0] rs);
		logic sa, sw, sb;
		int   n;
		@(posedge aclk);
		awaddr  <= {idx, 2'b00};
		wdata   <= {16'h0000, v};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(negedge aclk);
			sa = awvalid && awready;
			sw = wvalid && wready;
			sb = bvalid;
			rs = bresp;
			@(posedge aclk);
			if (sa)
				awvalid <= 1'b0;
			if (sw)
				wvalid <= 1'b0;
			if (sb === 1'b1)
				break;
		end
		bready <= 1'b0;
		if (n == 50)
			fail_wait();
	endtask

	task automatic rd(input logic [29:0] idx, output logic [31:0] v, output logic [1:0] rs);
		logic sa, sr;
		int   n;
		@(posedge aclk);
		araddr  <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(negedge aclk);
			sa = arvalid && arready;
			sr = rvalid;
			v  = rdata;
			rs = rresp;
			@(posedge aclk);
			if (sa)
				arvalid <= 1'b0;
			if (sr === 1'b1)
				break;
		end
		rready <= 1'b0;
		if (n == 50)
			fail_wait();
	endtask

	task automatic wrc(input logic [29:0] idx, input logic [15:0] v);
		logic [1:0] rs;
		wr(idx, v, rs);
		chk_resp(rs, hpr_pkg::RESP_OKAY);
	endtask

	task automatic rdc(input logic [29:0] idx, input logic [15:0] exp);
		logic [31:0] v;
		logic [1:0]  rs;
		rd(idx, v, rs);
		chk(v, {16'h0000, exp}, "read data");
		chk_resp(rs, hpr_pkg::RESP_OKAY);
	endtask

	initial
	begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(hpr_pkg::IDX_EQ, 16'h0018);
		for (i = 0; i < 3; i++)
		begin
			rdc(hpr_pkg::IDX_PAIR_BASE + 30'(2 * i), 16'h0080);
			rdc(hpr_pkg::IDX_PAIR_BASE + 30'(2 * i + 1), 16'h0000);
		end
		chk(ctrl.left_balance, 32'h0080_0000, "left reset");
		chk(ctrl.right_balance, 32'h0080_0000, "right reset");
		chk(ctrl.volume, 32'h0080_0000, "volume reset");
		chk(ctrl.eq_gain_half_db, 32'h0000_0000, "gain reset");
		chk(ctrl.eq_freq_hz, 32'h0000_0078, "band reset");
		$display("test reset done");
		for (i = 0; i < 7; i++)
		begin
			wrc(hpr_pkg::IDX_EQ, {5'h00, i[2:0], 2'h0, GC[i][5:0]});
			chk(ctrl.eq_freq_hz, HZ[i], "band");
			chk(ctrl.eq_gain_half_db, 32'(24 - GC[i]), "gain");
			chk(ctrl.eq_band, 32'(i), "band code");
			chk(ctrl.eq_band_valid, 32'h1, "band valid");
			rdc(hpr_pkg::IDX_EQ, {5'h00, i[2:0], 2'h0, GC[i][5:0]});
		end
		// undefined band and gain codes; reserved bits kept zero as a host must
		wrc(hpr_pkg::IDX_EQ, 16'h073F);
		rdc(hpr_pkg::IDX_EQ, 16'h073F);
		chk(ctrl.eq_band_valid, 32'h0, "band 7");
		chk(ctrl.eq_freq_hz, 32'h0, "band 7 frequency");
		chk(ctrl.eq_gain_half_db, 32'hFFFF_FFE8, "gain clamp");
		$display("test equalizer done");
		for (i = 0; i < 3; i++)
		begin
			hi = (i == 0) ? 12'h800 : (i == 1) ? 12'h7FF : 12'h001;
			lo = (i == 0) ? 16'h1234 : (i == 1) ? 16'hFFFF : 16'h0000;
			ix = hpr_pkg::IDX_PAIR_BASE + 30'(2 * i);
			// the right pair is written low half first to cover either order
			wrc((i == 1) ? ix + 30'h1 : ix, (i == 1) ? lo : {4'h0, hi});
			d = (i == 0) ? 32'(ctrl.left_balance) : (i == 1) ? 32'(ctrl.right_balance) : 32'(ctrl.volume);
			chk(d, 32'h0080_0000, "half written");
			wrc((i == 1) ? ix : ix + 30'h1, (i == 1) ? {4'h0, hi} : lo);
			d = (i == 0) ? 32'(ctrl.left_balance) : (i == 1) ? 32'(ctrl.right_balance) : 32'(ctrl.volume);
			chk(d, {{4{hi[11]}}, hi, lo}, "coefficient");
			rdc(ix, {4'h0, hi});
		end
		$display("test coefficients done");
		for (i = 0; i < 3; i++)
		begin
			wrc(hpr_pkg::IDX_DECAY, 16'(DC[i]));
			chk(ctrl.decay_rate_dbs, 32'((DC[i] + 1) * 10), "decay rate");
			chk(ctrl.decay_code, 32'(DC[i]), "decay code");
		end
		$display("test decay done");
		wr(30'h0000_0200, 16'h1234, r);
		chk_resp(r, hpr_pkg::RESP_SLVERR);
		rd(30'h0000_0200, d, r);
		chk(d, 32'h0000_0000, "unmapped data");
		chk_resp(r, hpr_pkg::RESP_SLVERR);
		$display("test unmapped done");
		close_out();
	end
endmodule
